// *** logic/aom_map.vh ***
// Register map, field positions, thresholds and timing for the analog monitor
`ifndef AOM_MAP_VH
`define AOM_MAP_VH

`define AOM_CLK_KHZ 200000
`define AOM_SAMPLE_MS 20
`define AOM_QUAL_MS 400
`define AOM_SAMPLE_CYC (`AOM_SAMPLE_MS * `AOM_CLK_KHZ)
`define AOM_QUAL_CYC (`AOM_QUAL_MS * `AOM_CLK_KHZ)

// Current in microamps, voltages in millivolts
`define AOM_I_UNDER 16'h0fa0
`define AOM_I_OVER 16'h4e20
`define AOM_I_LIMIT 16'h5dc0
`define AOM_LOOP_MAX 16'h4e20

`define AOM_A_VIN 5'h00
`define AOM_A_IIN 5'h01
`define AOM_A_LOOP 5'h02
`define AOM_A_VTHR 5'h03
`define AOM_A_ITHR 5'h04
`define AOM_A_CTRL 5'h05
`define AOM_A_STAT4 5'h06
`define AOM_A_MASK4 5'h07
`define AOM_A_STAT9 5'h08
`define AOM_A_MASK9 5'h09
`define AOM_A_VSEL 5'h0a
`define AOM_A_VMAN 5'h0b
`define AOM_A_VMIN 5'h0c
`define AOM_A_VMAX 5'h0d
`define AOM_A_ISEL 5'h0e
`define AOM_A_IMAN 5'h0f
`define AOM_A_IMIN 5'h10
`define AOM_A_IMAX 5'h11

`define AOM_CTRL_VTRIP 0
`define AOM_CTRL_ITRIP 1
`define AOM_CTRL_VOUT 2
`define AOM_CTRL_IOUT 3

`define AOM_S4_LOOPHOT 0
`define AOM_S4_VOUTHOT 1
`define AOM_S4_IOUTLOAD 2
`define AOM_S4_UNDER 3
`define AOM_S4_OVER 4
`define AOM_S9_VTRIP 3
`define AOM_S9_ITRIP 4

`define AOM_SEL_CONST 8'hff
`define AOM_SEL_LAST 8'h05

`endif

// *** logic/aom_monitor.v ***
// Analog input supervision, overpressure trip and analog output sourcing
//
// Overview of operation
// - Latch voltage and current readings together every 20 ms.
// - Current reading is stored as unsigned magnitude, sign dropped.
// - Group 4 bit 3 sets when current reading is below 4 mA.
// - Group 4 bit 4 sets when current reading is above 20 mA.
// - Group 4 bit 0 sets on loop supply overheating fault.
// - Current beyond 24 mA either polarity drops loop supply drive to zero.
// - Loop setpoint holds 0 to 20 V, clamped, readable back.
// - Overpressure declared after input above threshold 400 ms unbroken.
// - Two trip channels, voltage and current, own threshold and enable.
// - Trip pulses filament off, multiplier off if active, rod drives off.
// - Group 9 bit 3 for voltage trip, bit 4 for current trip.
// - Overpressure LED lit on trip until group 9 status is read.
// - Group 4 bit 1 sets on voltage output overheat while enabled.
// - Group 4 bit 2 sets on current output load fault while enabled.
// - Each output carries manual value or follows a selected measurement.
// - Selector -1 is manual; 0 to 5 pick the six measurements.
// - Followed measurements clamp to min and max; manual is unclamped.
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "aom_map.vh"

module aom_monitor #(
    parameter integer SAMPLE_CYC = `AOM_SAMPLE_CYC,
    parameter integer QUAL_CYC = `AOM_QUAL_CYC
) (
    input wire ref_clk,
    input wire srst,
    input wire [4:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    input wire signed [15:0] adc_volt_mv,
    input wire signed [15:0] adc_curr_ua,
    input wire loop_hot_pin,
    input wire vout_hot_pin,
    input wire iout_load_pin,
    input wire electron_multiplier_on,
    input wire [15:0] meas_scan,
    input wire [15:0] meas_mass,
    input wire [15:0] meas_flange,
    input wire [15:0] meas_rtd,
    input wire [15:0] meas_emis,
    input wire [15:0] meas_press,
    output reg [15:0] loop_drive,
    output reg [15:0] vout_value,
    output reg vout_enable,
    output reg [15:0] iout_value,
    output reg iout_enable,
    output reg filament_off,
    output reg electron_multiplier_off,
    output reg rods_off,
    output reg overpressure_led,
    output reg irq
);

    // ***************************************************************
    // Functions
    // ***************************************************************
    function [15:0] aom_mag;
        input [15:0] v;
        begin
            aom_mag = v[15] ? (~v + 16'h0001) : v;
        end
    endfunction

    function [15:0] aom_pick;
        input [7:0] sel;
        input [15:0] man;
        input [15:0] lo;
        input [15:0] hi;
        input [95:0] meas;
        reg [15:0] m;
        begin
            m = 16'h0000;
            case (sel)
                8'h00: m = meas[15:0];
                8'h01: m = meas[31:16];
                8'h02: m = meas[47:32];
                8'h03: m = meas[63:48];
                8'h04: m = meas[79:64];
                8'h05: m = meas[95:80];
                default: m = 16'h0000;
            endcase
            if (sel == `AOM_SEL_CONST) begin
                aom_pick = man;
            end else if (m < lo) begin
                aom_pick = lo;
            end else if (m > hi) begin
                aom_pick = hi;
            end else begin
                aom_pick = m;
            end
        end
    endfunction

    // ***************************************************************
    // Pin synchronisers
    // ***************************************************************
    // Fault pins come from analog comparators, not from this clock
    reg [2:0] pin_meta_r;
    reg [2:0] pin_sync_r;

    always @(posedge ref_clk) begin
        if (srst) begin
            pin_meta_r <= 3'h0;
            pin_sync_r <= 3'h0;
        end else begin
            pin_meta_r <= {iout_load_pin, vout_hot_pin, loop_hot_pin};
            pin_sync_r <= pin_meta_r;
        end
    end

    // ***************************************************************
    // Sample timer and readings
    // ***************************************************************
    reg [22:0] samp_cnt_r;
    reg samp_tick_r;
    reg [15:0] vin_r;
    reg [15:0] iin_r;
    reg iin_limit_r;

    always @(posedge ref_clk) begin
        if (srst) begin
            samp_cnt_r <= 23'h000000;
            samp_tick_r <= 1'b0;
        end else if (samp_cnt_r == SAMPLE_CYC[22:0] - 23'h000001) begin
            samp_cnt_r <= 23'h000000;
            samp_tick_r <= 1'b1;
        end else begin
            samp_cnt_r <= samp_cnt_r + 23'h000001;
            samp_tick_r <= 1'b0;
        end
    end

    always @(posedge ref_clk) begin
        if (srst) begin
            vin_r <= 16'h0000;
            iin_r <= 16'h0000;
            iin_limit_r <= 1'b0;
        end else if (samp_tick_r) begin
            vin_r <= adc_volt_mv;
            iin_r <= aom_mag(adc_curr_ua);
            iin_limit_r <= aom_mag(adc_curr_ua) > `AOM_I_LIMIT;
        end
    end

    // ***************************************************************
    // Configuration registers
    // ***************************************************************
    reg [15:0] loop_set_r;
    reg [15:0] vthr_r;
    reg [15:0] ithr_r;
    reg [3:0] ctrl_r;
    reg [4:0] mask4_r;
    reg [1:0] mask9_r;
    reg [7:0] vsel_r;
    reg [15:0] vman_r;
    reg [15:0] vmin_r;
    reg [15:0] vmax_r;
    reg [7:0] isel_r;
    reg [15:0] iman_r;
    reg [15:0] imin_r;
    reg [15:0] imax_r;

    always @(posedge ref_clk) begin
        if (srst) begin
            loop_set_r <= 16'h0000;
            vthr_r <= 16'h0000;
            ithr_r <= 16'h0000;
            ctrl_r <= 4'h0;
            mask4_r <= 5'h00;
            mask9_r <= 2'h0;
            vsel_r <= `AOM_SEL_CONST;
            vman_r <= 16'h0000;
            vmin_r <= 16'h0000;
            vmax_r <= 16'hffff;
            isel_r <= `AOM_SEL_CONST;
            iman_r <= 16'h0000;
            imin_r <= 16'h0000;
            imax_r <= 16'hffff;
        end else if (reg_wr) begin
            case (reg_addr)
                `AOM_A_LOOP: begin
                    if (reg_wdata > `AOM_LOOP_MAX) begin
                        loop_set_r <= `AOM_LOOP_MAX;
                    end else begin
                        loop_set_r <= reg_wdata;
                    end
                end
                `AOM_A_VTHR: vthr_r <= reg_wdata;
                `AOM_A_ITHR: ithr_r <= reg_wdata;
                `AOM_A_CTRL: ctrl_r <= reg_wdata[3:0];
                `AOM_A_MASK4: mask4_r <= reg_wdata[4:0];
                `AOM_A_MASK9: mask9_r <= reg_wdata[4:3];
                `AOM_A_VSEL: begin
                    // Unknown codes are refused so the output never floats
                    if (reg_wdata[7:0] == `AOM_SEL_CONST ||
                        reg_wdata[7:0] <= `AOM_SEL_LAST) begin
                        vsel_r <= reg_wdata[7:0];
                    end
                end
                `AOM_A_VMAN: vman_r <= reg_wdata;
                `AOM_A_VMIN: vmin_r <= reg_wdata;
                `AOM_A_VMAX: vmax_r <= reg_wdata;
                `AOM_A_ISEL: begin
                    if (reg_wdata[7:0] == `AOM_SEL_CONST ||
                        reg_wdata[7:0] <= `AOM_SEL_LAST) begin
                        isel_r <= reg_wdata[7:0];
                    end
                end
                `AOM_A_IMAN: iman_r <= reg_wdata;
                `AOM_A_IMIN: imin_r <= reg_wdata;
                `AOM_A_IMAX: imax_r <= reg_wdata;
                default: ;
            endcase
        end
    end

    // ***************************************************************
    // Overpressure qualification
    // ***************************************************************
    reg [26:0] vq_cnt_r;
    reg [26:0] iq_cnt_r;
    reg v_trip_r;
    reg i_trip_r;
    wire v_above = $signed(vin_r) > $signed(vthr_r);
    wire i_above = iin_r > ithr_r;
    // Pulse once the count reaches the full span, never one cycle early
    wire [26:0] qual_last = QUAL_CYC[26:0];

    always @(posedge ref_clk) begin
        if (srst || !ctrl_r[`AOM_CTRL_VTRIP] || !v_above) begin
            vq_cnt_r <= 27'h0000000;
            v_trip_r <= 1'b0;
        end else if (vq_cnt_r != qual_last) begin
            vq_cnt_r <= vq_cnt_r + 27'h0000001;
            v_trip_r <= (vq_cnt_r + 27'h0000001) == qual_last;
        end else begin
            v_trip_r <= 1'b0;
        end
    end

    always @(posedge ref_clk) begin
        if (srst || !ctrl_r[`AOM_CTRL_ITRIP] || !i_above) begin
            iq_cnt_r <= 27'h0000000;
            i_trip_r <= 1'b0;
        end else if (iq_cnt_r != qual_last) begin
            iq_cnt_r <= iq_cnt_r + 27'h0000001;
            i_trip_r <= (iq_cnt_r + 27'h0000001) == qual_last;
        end else begin
            i_trip_r <= 1'b0;
        end
    end

    // ***************************************************************
    // Status, interrupt and trip actions
    // ***************************************************************
    reg [4:0] stat4_r;
    reg [1:0] stat9_r;
    reg [4:0] set4;
    wire [1:0] set9 = {i_trip_r, v_trip_r};
    wire trip = v_trip_r | i_trip_r;
    wire rd9 = reg_rd && reg_addr == `AOM_A_STAT9;

    always @* begin
        set4 = 5'h00;
        set4[`AOM_S4_LOOPHOT] = pin_sync_r[0];
        set4[`AOM_S4_VOUTHOT] = pin_sync_r[1] & ctrl_r[`AOM_CTRL_VOUT];
        set4[`AOM_S4_IOUTLOAD] = pin_sync_r[2] & ctrl_r[`AOM_CTRL_IOUT];
        set4[`AOM_S4_UNDER] = iin_r < `AOM_I_UNDER;
        set4[`AOM_S4_OVER] = iin_r > `AOM_I_OVER;
    end

    // Set wins over a write-one clear landing in the same cycle
    always @(posedge ref_clk) begin
        if (srst) begin
            stat4_r <= 5'h00;
            stat9_r <= 2'h0;
        end else begin
            if (reg_wr && reg_addr == `AOM_A_STAT4) begin
                stat4_r <= (stat4_r & ~reg_wdata[4:0]) | set4;
            end else begin
                stat4_r <= stat4_r | set4;
            end
            if (reg_wr && reg_addr == `AOM_A_STAT9) begin
                stat9_r <= (stat9_r & ~reg_wdata[4:3]) | set9;
            end else begin
                stat9_r <= stat9_r | set9;
            end
        end
    end

    always @(posedge ref_clk) begin
        if (srst) begin
            filament_off <= 1'b0;
            electron_multiplier_off <= 1'b0;
            rods_off <= 1'b0;
            overpressure_led <= 1'b0;
            irq <= 1'b0;
        end else begin
            filament_off <= trip;
            electron_multiplier_off <= trip & electron_multiplier_on;
            rods_off <= trip;
            if (trip) begin
                overpressure_led <= 1'b1;
            end else if (rd9) begin
                overpressure_led <= 1'b0;
            end
            irq <= |(stat4_r & mask4_r) | |(stat9_r & mask9_r);
        end
    end

    // ***************************************************************
    // Loop supply and analog outputs
    // ***************************************************************
    always @(posedge ref_clk) begin
        if (srst) begin
            loop_drive <= 16'h0000;
            vout_value <= 16'h0000;
            vout_enable <= 1'b0;
            iout_value <= 16'h0000;
            iout_enable <= 1'b0;
        end else begin
            // Crude backoff: full removal is safest until the loop recovers
            loop_drive <= iin_limit_r ? 16'h0000 : loop_set_r;
            vout_enable <= ctrl_r[`AOM_CTRL_VOUT];
            iout_enable <= ctrl_r[`AOM_CTRL_IOUT];
            vout_value <= aom_pick(vsel_r, vman_r, vmin_r, vmax_r,
                {meas_press, meas_emis, meas_rtd, meas_flange, meas_mass,
                 meas_scan});
            iout_value <= aom_pick(isel_r, iman_r, imin_r, imax_r,
                {meas_press, meas_emis, meas_rtd, meas_flange, meas_mass,
                 meas_scan});
        end
    end

    // ***************************************************************
    // Read port
    // ***************************************************************
    always @(posedge ref_clk) begin
        if (srst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `AOM_A_VIN: reg_rdata <= vin_r;
                `AOM_A_IIN: reg_rdata <= iin_r;
                `AOM_A_LOOP: reg_rdata <= loop_set_r;
                `AOM_A_VTHR: reg_rdata <= vthr_r;
                `AOM_A_ITHR: reg_rdata <= ithr_r;
                `AOM_A_CTRL: reg_rdata <= {12'h000, ctrl_r};
                `AOM_A_STAT4: reg_rdata <= {11'h000, stat4_r};
                `AOM_A_MASK4: reg_rdata <= {11'h000, mask4_r};
                `AOM_A_STAT9: reg_rdata <= {11'h000, stat9_r, 3'h0};
                `AOM_A_MASK9: reg_rdata <= {11'h000, mask9_r, 3'h0};
                `AOM_A_VSEL: reg_rdata <= {8'h00, vsel_r};
                `AOM_A_VMAN: reg_rdata <= vman_r;
                `AOM_A_VMIN: reg_rdata <= vmin_r;
                `AOM_A_VMAX: reg_rdata <= vmax_r;
                `AOM_A_ISEL: reg_rdata <= {8'h00, isel_r};
                `AOM_A_IMAN: reg_rdata <= iman_r;
                `AOM_A_IMIN: reg_rdata <= imin_r;
                `AOM_A_IMAX: reg_rdata <= imax_r;
                default: reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

endmodule
`default_nettype wire

// *** testbench/aom_sensor_model.sv ***
// Transducer model that feeds the monitor ADC inputs
`timescale 1ns/1ps
`default_nettype none
// ****
// Sensor model
// ****
module aom_sensor_model #(
    parameter integer LAG = 3
) (
    input wire logic ref_clk,
    input wire logic signed [15:0] volt_cmd,
    input wire logic signed [15:0] curr_cmd,
    output var logic signed [15:0] adc_volt_mv,
    output var logic signed [15:0] adc_curr_ua
);
    logic signed [15:0] v_q = 16'sh0000;
    logic signed [15:0] i_q = 16'sh0000;
    integer cnt = 0;
    // A real transducer settles slowly, so new levels show LAG+1 cycles after they are taken
    always @(posedge ref_clk) begin
        if (volt_cmd !== v_q || curr_cmd !== i_q) begin
            v_q <= volt_cmd;
            i_q <= curr_cmd;
            cnt <= LAG;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end else begin
            adc_volt_mv <= v_q;
            adc_curr_ua <= i_q;
        end
    end
endmodule
`default_nettype wire

// *** testbench/aom_monitor_sva.sv ***
// Concurrent checks on the analog monitor ports
`timescale 1ns/1ps
`default_nettype none
`include "aom_map.vh"
// ****
// Checker
// ****
module aom_monitor_sva #(
    parameter integer SAMPLE_CYC = 20,
    parameter integer QUAL_CYC = 50
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [4:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic electron_multiplier_on,
    input wire logic [15:0] loop_drive,
    input wire logic vout_enable,
    input wire logic iout_enable,
    input wire logic filament_off,
    input wire logic electron_multiplier_off,
    input wire logic rods_off,
    input wire logic overpressure_led
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    AST_LOOP_MAX: assert property (loop_drive <= 16'h4e20)
        else $error("loop drive above limit");
    AST_LOOP_READ: assert property (reg_rd && reg_addr == `AOM_A_LOOP
        |=> reg_rdata <= 16'h4e20) else $error("loop setpoint above limit");
    AST_FIL_PULSE: assert property (filament_off |=> !filament_off)
        else $error("filament off pulse too long");
    AST_SHUTDOWN: assert property (filament_off |-> rods_off)
        else $error("rods not shut down with filament");
    AST_EM_OFF: assert property (electron_multiplier_off
        |-> filament_off && $past(electron_multiplier_on))
        else $error("multiplier off pulse unexpected");
    AST_LED_HOLD: assert property (overpressure_led
        && !(reg_rd && reg_addr == `AOM_A_STAT9) |=> overpressure_led)
        else $error("indicator dropped without status read");
    AST_LED_RISE: assert property ($rose(overpressure_led)
        |-> filament_off) else $error("indicator lit without shutdown");
    AST_OUT_EN: assert property (reg_wr && reg_addr == `AOM_A_CTRL
        |-> ##2 vout_enable == $past(reg_wdata[`AOM_CTRL_VOUT], 2)
        && iout_enable == $past(reg_wdata[`AOM_CTRL_IOUT], 2))
        else $error("output enables do not follow control");
    COV_TRIP_EM: cover property (electron_multiplier_off);
    COV_LED_READ: cover property ($fell(overpressure_led));
    COV_LOOP_WR: cover property (reg_wr && reg_addr == `AOM_A_LOOP);
endmodule
bind aom_monitor aom_monitor_sva #(
    .SAMPLE_CYC(SAMPLE_CYC),
    .QUAL_CYC(QUAL_CYC)
) u_aom_monitor_sva (
    .ref_clk(ref_clk),
    .srst(srst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .electron_multiplier_on(electron_multiplier_on),
    .loop_drive(loop_drive),
    .vout_enable(vout_enable),
    .iout_enable(iout_enable),
    .filament_off(filament_off),
    .electron_multiplier_off(electron_multiplier_off),
    .rods_off(rods_off),
    .overpressure_led(overpressure_led)
);
`default_nettype wire

// *** testbench/aom_monitor_tb.sv ***
// Self-checking bench for the analog monitor
`timescale 1ns/1ps
`default_nettype none
`include "aom_map.vh"
// ****
// Bench
// ****
module aom_monitor_tb;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic [4:0] reg_addr = 5'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic signed [15:0] volt_cmd = 16'sh0000;
    logic signed [15:0] curr_cmd = 16'sh0000;
    logic hot_l = 1'b0;
    logic hot_v = 1'b0;
    logic load_i = 1'b0;
    logic em_on = 1'b0;
    logic [15:0] meas [0:5];
    logic [15:0] ex;
    wire logic signed [15:0] adc_v;
    wire logic signed [15:0] adc_i;
    wire logic [15:0] rdata, loop_drive, vout, iout;
    wire logic vout_en, iout_en, fil_off, em_off, rods, led, irq;
    integer failures = 0;
    integer check_count = 0;
    integer k;
    always #2.5 ref_clk = ~ref_clk;
    aom_sensor_model u_aom_sensor_model (.ref_clk(ref_clk),
        .volt_cmd(volt_cmd), .curr_cmd(curr_cmd),
        .adc_volt_mv(adc_v), .adc_curr_ua(adc_i));
    // Short counts keep the run brief; sampling shorter than qualification
    aom_monitor #(.SAMPLE_CYC(20), .QUAL_CYC(50)) u_aom_monitor (
        .ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(rdata), .adc_volt_mv(adc_v), .adc_curr_ua(adc_i),
        .loop_hot_pin(hot_l), .vout_hot_pin(hot_v), .iout_load_pin(load_i),
        .electron_multiplier_on(em_on), .meas_scan(meas[0]),
        .meas_mass(meas[1]), .meas_flange(meas[2]), .meas_rtd(meas[3]),
        .meas_emis(meas[4]), .meas_press(meas[5]), .loop_drive(loop_drive),
        .vout_value(vout), .vout_enable(vout_en), .iout_value(iout),
        .iout_enable(iout_en), .filament_off(fil_off),
        .electron_multiplier_off(em_off), .rods_off(rods),
        .overpressure_led(led), .irq(irq));
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        check_count = check_count + 1;
        if (g !== e) begin
            failures = failures + 1;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task rdc(input string nm, input logic [4:0] a, input logic [15:0] m,
        input logic [15:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk(nm, e, rdata & m);
    endtask
    task wt(input integer n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // Bounded wait for the one-cycle shutdown pulse
    task trip(input logic e_em, input integer e_n);
        integer n;
        logic seen;
        seen = 1'b0;
        for (n = 0; n < 400 && !seen; n = n + 1) begin
            @(posedge ref_clk);
            #1;
            if (fil_off === 1'b1) seen = 1'b1;
        end
        chk("trip", 16'h0001, {15'h0000, seen});
        // Zero skips the timing check where the sample phase is unknown
        if (e_n > 0) chk("trip_delay", e_n[15:0], n[15:0]);
        chk("rods_off", 16'h0001, {15'h0000, rods});
        chk("em_off", {15'h0000, e_em}, {15'h0000, em_off});
        chk("led", 16'h0001, {15'h0000, led});
    endtask
    task complete_run;
        if (failures == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        for (k = 0; k < 6; k = k + 1) meas[k] = 16'h0100 * (k + 1);
        repeat (4) @(posedge ref_clk);
        srst <= 1'b0;
        rdc("vsel", `AOM_A_VSEL, 16'hffff, 16'h00ff);
        rdc("unmapped", 5'h1f, 16'hffff, 16'h0000);
        wr(`AOM_A_LOOP, 16'h5000);
        rdc("loop", `AOM_A_LOOP, 16'hffff, 16'h4e20);
        curr_cmd <= -16'sd25000;
        wt(40);
        chk("loop_drive", 16'h0000, loop_drive);
        rdc("iin", `AOM_A_IIN, 16'hffff, 16'h61a8);
        curr_cmd <= 16'sd3000;
        wt(40);
        chk("loop_drive", 16'h4e20, loop_drive);
        wr(`AOM_A_STAT4, 16'h0018);
        wt(2);
        rdc("stat4", `AOM_A_STAT4, 16'h0018, 16'h0008);
        wr(`AOM_A_MASK4, 16'h0008);
        wt(3);
        chk("irq", 16'h0001, {15'h0000, irq});
        curr_cmd <= 16'sd5000;
        wt(40);
        wr(`AOM_A_STAT4, 16'h001f);
        wt(3);
        chk("irq", 16'h0000, {15'h0000, irq});
        rdc("iin", `AOM_A_IIN, 16'hffff, 16'h1388);
        hot_l <= 1'b1;
        hot_v <= 1'b1;
        load_i <= 1'b1;
        wt(6);
        rdc("stat4", `AOM_A_STAT4, 16'h0007, 16'h0001);
        wr(`AOM_A_CTRL, 16'h000c);
        wt(6);
        rdc("stat4", `AOM_A_STAT4, 16'h0007, 16'h0007);
        hot_l <= 1'b0;
        hot_v <= 1'b0;
        load_i <= 1'b0;
        wr(`AOM_A_CTRL, 16'h0000);
        wr(`AOM_A_VTHR, 16'h03e8);
        em_on <= 1'b1;
        wr(`AOM_A_CTRL, 16'h0001);
        volt_cmd <= 16'sd2000;
        wt(22);
        volt_cmd <= 16'sd500;
        wt(80);
        rdc("stat9", `AOM_A_STAT9, 16'h0018, 16'h0000);
        volt_cmd <= 16'sd2000;
        trip(1'b1, 0);
        wt(10);
        rdc("vin", `AOM_A_VIN, 16'hffff, 16'h07d0);
        chk("led", 16'h0001, {15'h0000, led});
        rdc("stat9", `AOM_A_STAT9, 16'h0018, 16'h0008);
        chk("led", 16'h0000, {15'h0000, led});
        volt_cmd <= 16'sd0;
        wr(`AOM_A_CTRL, 16'h0000);
        em_on <= 1'b0;
        wr(`AOM_A_ITHR, 16'h2710);
        curr_cmd <= -16'sd12000;
        wt(80);
        rdc("stat9", `AOM_A_STAT9, 16'h0010, 16'h0000);
        wr(`AOM_A_CTRL, 16'h0002);
        trip(1'b0, 51);
        rdc("stat9", `AOM_A_STAT9, 16'h0018, 16'h0018);
        wr(`AOM_A_VMAN, 16'h1234);
        wr(`AOM_A_VMAX, 16'h0100);
        wt(3);
        chk("vout_manual", 16'h1234, vout);
        wr(`AOM_A_VMIN, 16'h0200);
        wr(`AOM_A_VMAX, 16'h0400);
        for (k = 0; k < 6; k = k + 1) begin
            wr(`AOM_A_VSEL, k[15:0]);
            wr(`AOM_A_ISEL, k[15:0]);
            wt(3);
            ex = meas[k] < 16'h0200 ? 16'h0200 : meas[k];
            ex = ex > 16'h0400 ? 16'h0400 : ex;
            chk("vout_meas", ex, vout);
            chk("iout_meas", meas[k], iout);
        end
        wr(`AOM_A_VSEL, 16'h0007);
        rdc("vsel", `AOM_A_VSEL, 16'hffff, 16'h0005);
        wr(`AOM_A_VSEL, 16'h00ff);
        wt(3);
        chk("vout_manual", 16'h1234, vout);
        complete_run;
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        failures = failures + 1;
        complete_run;
    end
endmodule
`default_nettype wire
